/* File: hdl/pcf_host_port.sv */
// host bus port, frame timing and command fifo of the pcm conference device
// Operation
// [RQ1] data bus floats while reset is low or chip select is high
// [RQ2] bus bit zero carries the least significant bit both ways
// [RQ3] write with qualifier low is data, high is an opcode
// [RQ4] legacy read: qualifier low gives first overflows, high last overflows and status
// [RQ5] transfers happen only while chip select is low
// [RQ6] read strobe fall drives the byte when the opcode matches
// [RQ7] write byte is captured at the write strobe rising edge
// [RQ8] clock rise before sync rise is first bit, or extra bit
// [RQ9] frames of 192, 193, 256 or 512 bits are supported
// [RQ10] legacy mode only allowed up to 256 bit frames
// [RQ11] matrix clock output copies the master clock
// [RQ12] extra bit mode cuts first two clock periods per frame
// [RQ13] input first bit sampled at second clock rise after sync rise
// [RQ14] extra bit mode moves input sampling two periods later
// [RQ15] law select high means a-law, low means mu-law
// [RQ16] host sets law select before reset and resets after change
// [RQ17] two frames of initialisation after reset with bus and output floating
// [RQ18] output sends sign first from rise before sync, open drain
// [RQ19] clock rises counted from sync rise give channel and bit
// [RQ20] host never asserts read and write strobes together
`timescale 1ns/1ns

// ========================================
// fifo
module pcf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic doPush;
    logic doPop;

    // handshakes
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign doPush = inValid && inReady;
    assign doPop = outValid && outReady;
    assign outData = mem[rdPtr_r];

    // storage
    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

// ========================================
// top
module pcf_host_port
    import pcf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic masterClock,
    input wire logic frameSync,
    input wire logic pcmIn,
    output logic pcmOut,
    output logic pcmOutOe,
    output logic matrixClockOut,
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic cmdData,
    input wire logic [DATA_W-1:0] hostDataBusIn,
    output logic [DATA_W-1:0] hostDataBusOut,
    output logic hostDataBusOe,
    input wire logic compandingLawSelect,
    output logic aLawMode,
    input wire logic legacyMode,
    output logic legacyActive,
    input wire logic readMatch,
    input wire logic [DATA_W-1:0] nativeReadByte,
    input wire logic [DATA_W-1:0] ovfFirst,
    input wire logic [1:0] ovfLast,
    input wire logic [STAT_W-1:0] statusBits,
    output pcf_hostWord_type cmdWord,
    output logic cmdValid,
    input wire logic cmdReady,
    output logic cmdFifoReady,
    output logic extraBitMode,
    output logic initDone,
    output pcf_pcmByte_type rxByte,
    output logic rxValid,
    input wire logic [DATA_W-1:0] txByte,
    output logic [CHAN_W-1:0] txChannel,
    output logic txLoad,
    output logic [POS_W-1:0] frameLen
);
    // ========================================
    // input synchronisers
    localparam int SYN_W = PIN_W + DATA_W;
    logic [SYN_W-1:0] meta_r;
    logic [SYN_W-1:0] sync_r;
    logic [PIN_W-1:0] prev_r;
    logic [PIN_W-1:0] pin;
    logic [DATA_W-1:0] busIn;

    // two flops on every pin, idle levels in reset so no false strobe edge follows release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= {PIN_IDLE, {DATA_W{1'b0}}};
            sync_r <= {PIN_IDLE, {DATA_W{1'b0}}};
        end else begin
            meta_r <= {masterClock, frameSync, pcmIn, csN, rdN, wrN, cmdData, hostDataBusIn};
            sync_r <= meta_r;
        end
    end

    assign pin = sync_r[SYN_W-1:DATA_W];
    assign busIn = sync_r[DATA_W-1:0];

    // previous values for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_r <= PIN_IDLE;
        end else begin
            prev_r <= pin;
        end
    end

    logic clkRise;
    logic syncRise;
    logic wrRise;
    logic rdFall;
    logic csActive;
    assign clkRise = pin[PIN_MCLK] && !prev_r[PIN_MCLK];
    assign syncRise = pin[PIN_SYNC] && !prev_r[PIN_SYNC];
    assign csActive = !pin[PIN_CS]; // [RQ5]
    assign wrRise = pin[PIN_WR] && !prev_r[PIN_WR] && csActive; // [RQ7]
    assign rdFall = !pin[PIN_RD] && prev_r[PIN_RD] && csActive && pin[PIN_WR]; // [RQ6] [RQ20]

    // ========================================
    // initialisation and law strap
    pcf_init_type initState_r;
    logic lawMeta_r;
    logic lawSync_r;

    // two frames pass before the port becomes active
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            initState_r <= INIT_WAIT;
        end else if (syncRise) begin
            case (initState_r)
                INIT_WAIT: initState_r <= INIT_ONE; // [RQ17]
                INIT_ONE: initState_r <= INIT_RUN;
                INIT_RUN: initState_r <= INIT_RUN;
                default: initState_r <= INIT_WAIT;
            endcase
        end
    end
    assign initDone = (initState_r == INIT_RUN);

    // law strap passes two flops, then is caught once at the first sync rise after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lawMeta_r <= LAW_RST;
            lawSync_r <= LAW_RST;
            aLawMode <= LAW_RST;
        end else begin
            lawMeta_r <= compandingLawSelect;
            lawSync_r <= lawMeta_r;
            if (syncRise && initState_r == INIT_WAIT) begin
                aLawMode <= lawSync_r; // [RQ15] [RQ16]
            end
        end
    end

    // ========================================
    // frame position counting
    logic [POS_W-1:0] pos_r;
    logic [POS_W-1:0] firstPos;
    logic [POS_W-1:0] bitIdx;
    logic sampleHere;
    assign firstPos = extraBitMode ? FIRST_BIT_POS + EXTRA_SHIFT : FIRST_BIT_POS; // [RQ14]
    assign bitIdx = pos_r - firstPos;

    // rises since the last sync rise, first rise after it is one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_r <= '0;
            frameLen <= FRAME_LEN_RST;
        end else if (syncRise) begin
            pos_r <= '0; // [RQ19]
            frameLen <= pos_r; // [RQ9]
        end else if (clkRise) begin
            pos_r <= pos_r + 1'b1;
        end
    end

    // legacy mode refused on frames longer than 256 bits
    assign legacyActive = legacyMode && (frameLen <= LEGACY_MAX_LEN); // [RQ10]

    // ========================================
    // matrix clock forwarding
    logic clkCut;
    // the rise that ends the cut is judged by the count it will reach
    assign clkCut = extraBitMode && ((clkRise ? pos_r + 1'b1 : pos_r) <= EXTRA_CLK_CUT);

    // copy of the master clock, held low for the cut periods
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            matrixClockOut <= 1'b0;
        end else begin
            matrixClockOut <= pin[PIN_MCLK] && !clkCut; // [RQ11] [RQ12]
        end
    end

    // ========================================
    // serial input
    logic [DATA_W-1:0] rxShift_r;
    assign sampleHere = clkRise && !syncRise && initDone && (pos_r + 1'b1 >= firstPos);

    // shift in msb first, deliver every eighth bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxShift_r <= '0;
            rxByte <= '0;
            rxValid <= 1'b0;
        end else begin
            rxValid <= 1'b0;
            if (sampleHere) begin
                rxShift_r <= {rxShift_r[DATA_W-2:0], pin[PIN_PCMIN]}; // [RQ13]
                if ((pos_r + 1'b1 - firstPos) == {bitIdx[POS_W-1:3], LAST_BIT}) begin
                    rxByte.data <= {rxShift_r[DATA_W-2:0], pin[PIN_PCMIN]};
                    rxByte.channel <= bitIdx[CHAN_W+2:3]; // [RQ19]
                    rxValid <= 1'b1;
                end
            end
        end
    end

    // ========================================
    // serial output, open drain
    logic [DATA_W-1:0] txShift_r;
    logic [2:0] txBit_r;
    logic txFirst;
    assign txFirst = clkRise && (pos_r + 1'b1 == frameLen); // [RQ8]

    // load at the rise before sync, then one byte per eight rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txShift_r <= '0;
            txBit_r <= '0;
            txChannel <= '0;
            txLoad <= 1'b0;
            pcmOutOe <= 1'b0;
        end else begin
            txLoad <= 1'b0;
            if (txFirst || (clkRise && txBit_r == LAST_BIT)) begin
                txShift_r <= txByte; // [RQ18]
                txBit_r <= '0;
                txChannel <= txFirst ? '0 : txChannel + 1'b1;
                txLoad <= 1'b1;
            end else if (clkRise) begin
                txShift_r <= {txShift_r[DATA_W-2:0], 1'b1};
                txBit_r <= txBit_r + 1'b1;
            end
            pcmOutOe <= initDone && !txShift_r[DATA_W-1]; // [RQ17] [RQ18]
        end
    end
    assign pcmOut = 1'b0;

    // ========================================
    // host writes through the command fifo
    pcf_hostWord_type pushWord;
    logic pushReady;
    assign pushWord = '{isOpcode: pin[PIN_CMD], data: busIn}; // [RQ2] [RQ3]
    assign cmdFifoReady = pushReady;

    pcf_fifo #(
        .WIDTH($bits(pcf_hostWord_type)),
        .DEPTH(FIFO_DEPTH)
    ) i_pcf_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(wrRise && initDone),
        .inReady(pushReady),
        .inData(pushWord),
        .outValid(cmdValid),
        .outReady(cmdReady),
        .outData(cmdWord)
    );

    // extra bit framing switched on by its opcode as it leaves the fifo
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            extraBitMode <= EXTRA_RST;
        end else if (cmdValid && cmdReady && cmdWord.isOpcode
                     && cmdWord.data == OPC_EXTRA_ON) begin
            extraBitMode <= 1'b1; // [RQ12]
        end
    end

    // ========================================
    // host reads
    logic readHeld_r;

    // latch the byte at the read strobe fall, hold while strobe low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readHeld_r <= 1'b0;
            hostDataBusOut <= '0;
        end else if (rdFall && initDone) begin
            if (legacyActive) begin
                readHeld_r <= 1'b1;
                hostDataBusOut <= pin[PIN_CMD] ? {statusBits, ovfLast} : ovfFirst; // [RQ4] [RQ2]
            end else begin
                readHeld_r <= readMatch; // [RQ6]
                hostDataBusOut <= nativeReadByte;
            end
        end else if (pin[PIN_RD] || !csActive) begin
            readHeld_r <= 1'b0;
        end
    end

    assign hostDataBusOe = rst_n && csActive && initDone && readHeld_r && !pin[PIN_RD]; // [RQ1]

    // ========================================
    // checks
    a_bus_float_cs: assert property (@(posedge clk) disable iff (!rst_n)
        !csActive |-> !hostDataBusOe) else $error("bus driven without chip select"); // [RQ1]
    a_float_init: assert property (@(posedge clk) disable iff (!rst_n)
        !initDone |-> !hostDataBusOe && !pcmOutOe) else $error("pins driven during init"); // [RQ17]
    a_opcode_qual: assert property (@(posedge clk) disable iff (!rst_n)
        wrRise && initDone && pushReady |-> pushWord.isOpcode == pin[PIN_CMD]
        && pushWord.data == busIn) else $error("write word mismatch"); // [RQ3]
    a_write_fill: assert property (@(posedge clk) disable iff (!rst_n)
        wrRise && initDone && pushReady && !cmdValid |=> cmdValid) else $error("write lost"); // [RQ7]
    a_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
        rdFall && initDone && !legacyActive && readMatch ##1 (csActive && !pin[PIN_RD])
        |-> hostDataBusOe && hostDataBusOut == $past(nativeReadByte)) else $error("read idle"); // [RQ6]
    a_legacy_low: assert property (@(posedge clk) disable iff (!rst_n)
        rdFall && initDone && legacyActive && !pin[PIN_CMD]
        |=> hostDataBusOut == $past(ovfFirst)) else $error("legacy low byte wrong"); // [RQ4]
    a_extra_cut: assert property (@(posedge clk) disable iff (!rst_n)
        extraBitMode && pos_r <= EXTRA_CLK_CUT && !syncRise ##1 pos_r <= EXTRA_CLK_CUT
        |-> !matrixClockOut) else $error("matrix clock not cut"); // [RQ12]
    a_clock_copy: assert property (@(posedge clk) disable iff (!rst_n)
        !extraBitMode ##1 !extraBitMode |-> matrixClockOut == $past(pin[PIN_MCLK]))
        else $error("matrix clock not a copy"); // [RQ11]
    a_sample_point: assert property (@(posedge clk) disable iff (!rst_n)
        sampleHere && !extraBitMode |-> pos_r + 1'b1 >= FIRST_BIT_POS)
        else $error("sample too early"); // [RQ13]
    a_legacy_limit: assert property (@(posedge clk) disable iff (!rst_n)
        frameLen > LEGACY_MAX_LEN |-> !legacyActive) else $error("legacy on long frame"); // [RQ10]

    c_write_seen: cover property (@(posedge clk) disable iff (!rst_n) wrRise && initDone);
    c_read_seen: cover property (@(posedge clk) disable iff (!rst_n) hostDataBusOe);
    c_fifo_full: cover property (@(posedge clk) disable iff (!rst_n) !pushReady);
    c_extra_on: cover property (@(posedge clk) disable iff (!rst_n) $rose(extraBitMode));
endmodule

/* File: hdl/pcf_pkg.sv */
// shared constants and types of the pcm conference host and frame port
package pcf_pkg;
    // ========================================
    // widths and depths
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int POS_W = 10;
    localparam int CHAN_W = 6;
    localparam int STAT_W = 6;
    // ========================================
    // synchroniser bit positions of the control pins
    localparam int PIN_W = 7;
    localparam int PIN_MCLK = 6;
    localparam int PIN_SYNC = 5;
    localparam int PIN_PCMIN = 4;
    localparam int PIN_CS = 3;
    localparam int PIN_RD = 2;
    localparam int PIN_WR = 1;
    localparam int PIN_CMD = 0;
    // idle levels of the control pins: chip select and both strobes high
    localparam logic [PIN_W-1:0] PIN_IDLE = 7'h0E;
    // ========================================
    // frame timing counts, in master clock rising edges
    localparam logic [POS_W-1:0] FIRST_BIT_POS = 10'h002;
    localparam logic [POS_W-1:0] EXTRA_SHIFT = 10'h002;
    localparam logic [POS_W-1:0] EXTRA_CLK_CUT = 10'h002;
    localparam logic [POS_W-1:0] LEGACY_MAX_LEN = 10'h100;
    localparam logic [POS_W-1:0] FRAME_LEN_RST = 10'h100;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // ========================================
    // opcodes and reset values
    localparam logic [DATA_W-1:0] OPC_EXTRA_ON = 8'h05;
    localparam logic EXTRA_RST = 1'b0;
    localparam logic LAW_RST = 1'b0;
    // ========================================
    // types
    typedef struct packed {
        logic isOpcode;
        logic [DATA_W-1:0] data;
    } pcf_hostWord_type;
    typedef struct packed {
        logic [CHAN_W-1:0] channel;
        logic [DATA_W-1:0] data;
    } pcf_pcmByte_type;
    typedef enum logic [1:0] {
        INIT_WAIT = 2'h0,
        INIT_ONE = 2'h1,
        INIT_RUN = 2'h3
    } pcf_init_type;
endpackage

/* File: tb/pcf_frame_src.sv */
// master clock, frame sync and serial pcm source of the switching matrix side
`timescale 1ns/1ns
module pcf_frame_src #(
    parameter int FLEN = 256,
    parameter int HALF = 4
) (
    input wire logic clk,
    input wire logic extraOn,
    output logic masterClock,
    output logic frameSync,
    output logic pcmIn
);
    int n;
    int idx;
    logic [7:0] pat;
    // ========================================
    // clock periods of one frame, sync after the last rise, data moved on falling edges
    initial begin
        masterClock = 1'h0;
        frameSync = 1'h0;
        pcmIn = 1'h1;
        forever begin
            for (int k = 1; k <= FLEN; k++) begin
                repeat (HALF) @(posedge clk);
                masterClock <= 1'h1;
                repeat (HALF) @(posedge clk);
                masterClock <= 1'h0;
                frameSync <= (k == FLEN);
                n = k % FLEN + 1;
                idx = n - (extraOn ? 4 : 2);
                pat = 8'((idx / 8) ^ 8'h5A);
                // sign bit first; outside the channels the line keeps toggling
                pcmIn <= (idx < 0) ? ~pcmIn : pat[7 - idx % 8];
            end
        end
    end
endmodule

/* File: tb/pcf_host_port_tb.sv */
// self-checking bench of the pcm conference host and frame port
`timescale 1ns/1ns
module pcf_host_port_tb;
    import pcf_pkg::*;
    localparam int FLEN = 256;
    logic clk, rst_n, masterClock, frameSync, pcmIn, pcmOut, pcmOutOe, matrixClockOut;
    logic csN, rdN, wrN, cmdData, hostDrive, lawSel, legacyMode, readMatch, cmdReady, extraOn;
    logic aLawMode, legacyActive, cmdValid, cmdFifoReady, extraBitMode, initDone;
    logic rxValid, txLoad, hostDataBusOe;
    logic [7:0] hostData, busIn, hostDataBusOut, ovfFirst;
    logic [1:0] ovfLast;
    logic [5:0] statusBits, txChannel;
    logic [9:0] frameLen;
    pcf_hostWord_type cmdWord;
    pcf_pcmByte_type rxByte;
    int num_errors = 0;
    int n_tests = 0;
    // resolved data bus, pulled up when nobody drives
    assign busIn = hostDataBusOe ? hostDataBusOut : (hostDrive ? hostData : 8'hFF);
    pcf_frame_src #(.FLEN(FLEN), .HALF(4)) i_pcf_frame_src (.clk(clk), .extraOn(extraOn),
        .masterClock(masterClock), .frameSync(frameSync), .pcmIn(pcmIn));
    pcf_host_port i_pcf_host_port (.clk(clk), .rst_n(rst_n), .masterClock(masterClock),
        .frameSync(frameSync), .pcmIn(pcmIn), .pcmOut(pcmOut), .pcmOutOe(pcmOutOe),
        .matrixClockOut(matrixClockOut), .csN(csN), .rdN(rdN), .wrN(wrN), .cmdData(cmdData),
        .hostDataBusIn(busIn), .hostDataBusOut(hostDataBusOut), .hostDataBusOe(hostDataBusOe),
        .compandingLawSelect(lawSel), .aLawMode(aLawMode), .legacyMode(legacyMode),
        .legacyActive(legacyActive), .readMatch(readMatch), .nativeReadByte(8'hC3),
        .ovfFirst(ovfFirst), .ovfLast(ovfLast), .statusBits(statusBits), .cmdWord(cmdWord),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdFifoReady(cmdFifoReady),
        .extraBitMode(extraBitMode), .initDone(initDone), .rxByte(rxByte), .rxValid(rxValid),
        .txByte(8'h96), .txChannel(txChannel), .txLoad(txLoad), .frameLen(frameLen));
    // ========================================
    // clock and time-zero values; reset and a selected read pending from the start
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst_n, csN, rdN, wrN, cmdData, hostDrive, readMatch, cmdReady, extraOn} = 9'h0;
        {wrN, lawSel, legacyMode} = 3'h7;
        hostData = 8'h00;
        ovfFirst = 8'hA6;
        ovfLast = 2'h1;
        statusBits = 6'h2D;
    end
    // ========================================
    // result comparison and verdict
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ========================================
    // host bus cycles, strobes held well beyond the synchroniser delay
    task automatic host_write(input logic cmd, input logic [7:0] d, input logic cs);
        @(posedge clk);
        csN <= ~cs;
        cmdData <= cmd;
        hostData <= d;
        hostDrive <= 1'h1;
        wrN <= 1'h0;
        repeat (5) @(posedge clk);
        wrN <= 1'h1;
        repeat (5) @(posedge clk);
        csN <= 1'h1;
        hostDrive <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic host_read(input logic cmd, input logic cs, output logic oe,
        output logic [7:0] d);
        @(posedge clk);
        csN <= ~cs;
        cmdData <= cmd;
        rdN <= 1'h0;
        repeat (6) @(posedge clk);
        #1;
        oe = hostDataBusOe;
        d = busIn;
        @(posedge clk);
        rdN <= 1'h1;
        repeat (5) @(posedge clk);
        csN <= 1'h1;
        repeat (3) @(posedge clk);
    endtask
    task automatic read_chk(input logic lg, input logic m, input logic cmd, input logic cs,
        input logic eOe, input logic [7:0] eD);
        logic oe;
        logic [7:0] d;
        legacyMode <= lg;
        readMatch <= m;
        host_read(cmd, cs, oe, d);
        check(oe, eOe, "read drive");
        if (eOe) check(d, eD, "read byte");
        check(hostDataBusOe, 1'h0, "bus released");
    endtask
    task automatic pop_chk(input logic [8:0] exp);
        for (int i = 0; i < 20 && cmdValid !== 1'h1; i++) @(posedge clk);
        check(cmdValid, 1'h1, "word waiting");
        check(cmdWord, exp, "word");
        cmdReady <= 1'h1;
        @(posedge clk);
        cmdReady <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    // ========================================
    // scenarios
    task automatic t_reset();
        repeat (5) @(posedge clk);
        check(hostDataBusOe, 1'h0, "drive in reset");
        check(pcmOutOe, 1'h0, "pcm drive in reset");
        rst_n <= 1'h1;
        csN <= 1'h1;
        rdN <= 1'h1;
        repeat (3) @(posedge clk);
        read_chk(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
        check(pcmOutOe, 1'h0, "pcm drive in init");
        for (int i = 0; i < 6000 && initDone !== 1'h1; i++) @(posedge clk);
        check(initDone, 1'h1, "init done");
        check(aLawMode, 1'h1, "law");
    endtask
    task automatic t_host();
        read_chk(1'h1, 1'h0, 1'h0, 1'h1, 1'h1, ovfFirst);
        read_chk(1'h1, 1'h0, 1'h1, 1'h1, 1'h1, {statusBits, ovfLast});
        read_chk(1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 8'h00);
        check(legacyActive, 1'h1, "legacy allowed");
        check(frameLen, FLEN, "frame length");
        read_chk(1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 8'h00);
        read_chk(1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 8'hC3);
        check(legacyActive, 1'h0, "legacy off");
        host_write(1'h0, 8'h3C, 1'h1);
        pop_chk({1'h0, 8'h3C});
        host_write(1'h1, 8'h81, 1'h1);
        pop_chk({1'h1, 8'h81});
        host_write(1'h0, 8'h11, 1'h0);
        check(cmdValid, 1'h0, "write without select");
    endtask
    task automatic t_fifo();
        for (int i = 0; i < 17; i++) begin
            host_write(1'h0, 8'(i), 1'h1);
            if (i == 15) check(cmdFifoReady, 1'h0, "fifo full");
        end
        for (int i = 0; i < 16; i++) pop_chk({1'h0, 8'(i)});
        check(cmdValid, 1'h0, "fifo empty");
    endtask
    task automatic frame_chk(input int expRises);
        int rises, loads, rx, oes, firsts;
        logic prev;
        {rises, loads, rx, oes, firsts} = 0;
        @(posedge frameSync);
        prev = matrixClockOut;
        repeat (FLEN * 8) begin
            @(posedge clk);
            rises += int'(matrixClockOut && !prev);
            prev = matrixClockOut;
            loads += int'(txLoad);
            oes += int'(pcmOutOe);
            firsts += int'(txLoad && txChannel == 6'h00);
            check(pcmOut, 1'h0, "open drain");
            if (rxValid && rxByte.channel < 31) begin
                rx++;
                check(rxByte.data, 8'({2'h0, rxByte.channel} ^ 8'h5A), "pcm byte");
            end
        end
        check(rises, expRises, "matrix clock rises");
        check(loads, FLEN / 8, "tx loads");
        // every byte sent is 0x96: four low bits of eight clocks each
        check(oes, FLEN * 4, "pcm low bits");
        check(firsts, 1, "channel zero loads");
        check(rx, 31, "rx bytes");
    endtask
    task automatic t_extra();
        check(extraBitMode, 1'h0, "extra off");
        host_write(1'h1, OPC_EXTRA_ON, 1'h1);
        pop_chk({1'h1, OPC_EXTRA_ON});
        check(extraBitMode, 1'h1, "extra on");
        extraOn <= 1'h1;
        frame_chk(FLEN - 2);
    endtask
    // ========================================
    // main sequence and watchdog
    initial begin
        t_reset();
        t_host();
        t_fifo();
        frame_chk(FLEN);
        t_extra();
        end_of_test();
    end
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
endmodule
